/* common/vep_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts
  for the pixel port front end. Assumes a 32-bit Avalon-MM word bus.
*/
`ifndef VEP_REGS_SVH
`define VEP_REGS_SVH

// Word offsets on the register bus
`define VEP_REG_CTRL      3'h0
`define VEP_REG_SC_INC    3'h1
`define VEP_REG_STATUS    3'h2
`define VEP_REG_SC_PHASE  3'h3
`define VEP_REG_TXT       3'h4

// Control register fields
`define VEP_CTRL_MASTER   0
`define VEP_CTRL_TM_LO    1
`define VEP_CTRL_TM_HI    2
`define VEP_CTRL_WIDE     3
`define VEP_CTRL_SC_LO    4
`define VEP_CTRL_SC_HI    5
`define VEP_CTRL_TXT_EN   6
`define VEP_CTRL_PAL      7
`define VEP_CTRL_DAC_B    8
`define VEP_CTRL_DAC_D    9
`define VEP_CTRL_OUT_LO   10
`define VEP_CTRL_OUT_HI   11
`define VEP_CTRL_BITS     12

// NTSC, slave, mode 0, 8-bit, dual composite + S-Video, B on, D off
`define VEP_CTRL_RST      12'h100
`define VEP_SC_INC_RST    32'h0000_0000

// Timing generator defaults, in clocks and lines
`define VEP_LINE_CLKS     12'h6B4
`define VEP_HSYNC_CLKS    12'h07E
`define VEP_FIELD_LINES   10'h106
`define VEP_VSYNC_LINES   10'h003
`define VEP_VBI_LINES     10'h014
`define VEP_PIPE_LAT      8'h30

// Upper six bits of the serial control slave address, arbitrary value
`define VEP_SLAVE_ADDR_HI 6'h2A

`endif

/* common/vep_pkg.sv */
/*
  Types shared by both ends of the pixel port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package vep_pkg;

  typedef logic [15:0] vep_pix_t;

  typedef enum logic [1:0] {
    VEP_TM0,
    VEP_TM1,
    VEP_TM2,
    VEP_TM3
  } vep_tmode_t;

  // Pin function order follows {hi, lo} of the two select bits
  typedef enum logic [1:0] {
    VEP_SC_OFF,
    VEP_SC_RESTART,
    VEP_SC_RTC,
    VEP_SC_IDLE
  } vep_sc_fn_t;

endpackage : vep_pkg

/* common/vep_if.sv */
/*
  Pin bundle between the video source and the encoder front end.
  Assumes both ends run on the same reference clock; resolves the
  two-way sync and blanking pins, idle level high (pull-up).
*/
`timescale 1ns/1ps
interface vep_if;
  import vep_pkg::*;

  vep_pix_t pixel_data_bus;
  logic     blank_src_o;
  logic     blank_src_oe;
  logic     hs_dev_o;
  logic     hs_dev_oe;
  logic     hs_src_o;
  logic     hs_src_oe;
  logic     fs_dev_o;
  logic     fs_dev_oe;
  logic     fs_src_o;
  logic     fs_src_oe;
  logic     pix_ready;
  logic     subcarrier_restart_or_realtime_ctl;
  logic     vbi_text_request;
  logic     vbi_text_data_in;
  logic     hsync;
  logic     fsync;
  logic     blank;

  assign hsync = hs_dev_oe ? hs_dev_o : (hs_src_oe ? hs_src_o : 1'b1);
  assign fsync = fs_dev_oe ? fs_dev_o : (fs_src_oe ? fs_src_o : 1'b1);
  assign blank = blank_src_oe ? blank_src_o : 1'b1;

  modport dev (
    input  pixel_data_bus, hsync, fsync, blank,
    input  subcarrier_restart_or_realtime_ctl, vbi_text_data_in,
    output hs_dev_o, hs_dev_oe, fs_dev_o, fs_dev_oe,
    output pix_ready, vbi_text_request
  );

  modport src (
    input  hsync, fsync, pix_ready, vbi_text_request,
    output pixel_data_bus, blank_src_o, blank_src_oe,
    output hs_src_o, hs_src_oe, fs_src_o, fs_src_oe,
    output subcarrier_restart_or_realtime_ctl, vbi_text_data_in
  );
endinterface : vep_if

/* hdl/vep_source.sv */
/*
  Video source end of the pixel port: drives pixels with blanking as
  a valid strobe, drives line and field sync while the encoder is a
  timing slave, and feeds teletext bits on request.
  Assumes the encoder shares clk_in.
*/
`timescale 1ns/1ps
`include "vep_regs.svh"
module vep_source #(
  parameter int LINE_CLKS   = `VEP_LINE_CLKS,
  parameter int HSYNC_CLKS  = `VEP_HSYNC_CLKS,
  parameter int FIELD_LINES = `VEP_FIELD_LINES,
  parameter int VSYNC_LINES = `VEP_VSYNC_LINES
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Pixel stream from user
  input  wire vep_pkg::vep_pix_t pix_in,
  input  wire logic             pix_valid_in,
  output logic                  pix_ready_out,
  // Timing setup
  input  wire logic             enc_master_in,
  input  wire logic             vsync_mode_in,
  // Side pins
  input  wire logic             scr_level_in,
  input  wire logic             txt_bit_in,
  output logic                  txt_req_seen_out,
  output logic                  hsync_seen_out,
  output logic                  fsync_seen_out,
  // Pins
  vep_if.src                    lnk
);
  import vep_pkg::*;

  logic        hold_r;
  vep_pix_t    data_r;
  logic [11:0] hcnt_r;
  logic [9:0]  lcnt_r;
  logic        field_r;
  logic        hs_r;
  logic        fs_r;
  logic        scr_r;
  logic        txt_r;
  logic        req_r;
  logic        hs_seen_r;
  logic        fs_seen_r;

  wire take     = ~hold_r | lnk.pix_ready;
  wire line_end = hcnt_r == 12'(LINE_CLKS - 1);
  wire fld_end  = lcnt_r == 10'(FIELD_LINES - 1);

  assign pix_ready_out          = take;
  assign lnk.pixel_data_bus     = data_r;
  assign lnk.blank_src_o        = hold_r;
  assign lnk.blank_src_oe       = 1'b1;
  assign lnk.hs_src_o           = hs_r;
  assign lnk.fs_src_o           = fs_r;
  assign lnk.hs_src_oe          = ~enc_master_in;
  assign lnk.fs_src_oe          = ~enc_master_in;
  assign lnk.subcarrier_restart_or_realtime_ctl = scr_r;
  assign lnk.vbi_text_data_in   = txt_r;
  assign txt_req_seen_out       = req_r;
  assign hsync_seen_out         = hs_seen_r;
  assign fsync_seen_out         = fs_seen_r;

  // Held word stays on the pins until the encoder takes it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r <= 1'b0;
      data_r <= 16'h0000;
    end else if (take) begin
      hold_r <= pix_valid_in;
      data_r <= pix_in;
    end
  end

  // Sync launched on the rising edge for a slave encoder
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hcnt_r  <= 12'h000;
      lcnt_r  <= 10'h000;
      field_r <= 1'b0;
      hs_r    <= 1'b1;
      fs_r    <= 1'b1;
    end else begin
      hcnt_r <= line_end ? 12'h000 : hcnt_r + 12'h001;
      if (line_end) begin
        lcnt_r <= fld_end ? 10'h000 : lcnt_r + 10'h001;
        if (fld_end) begin
          field_r <= ~field_r;
        end
      end
      hs_r <= hcnt_r >= 12'(HSYNC_CLKS);
      fs_r <= vsync_mode_in ? (lcnt_r >= 10'(VSYNC_LINES)) : field_r;
    end
  end

  // Teletext idles high unless the encoder asks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scr_r     <= 1'b0;
      txt_r     <= 1'b1;
      req_r     <= 1'b0;
      hs_seen_r <= 1'b1;
      fs_seen_r <= 1'b1;
    end else begin
      scr_r     <= scr_level_in;
      req_r     <= lnk.vbi_text_request;
      txt_r     <= lnk.vbi_text_request ? txt_bit_in : 1'b1;
      hs_seen_r <= lnk.hsync;
      fs_seen_r <= lnk.fsync;
    end
  end

endmodule : vep_source

/* hdl/vep_device.sv */
/*
  Encoder front end: pixel port with blanking, sync pins in master or
  slave timing, subcarrier phase with restart / real-time control
  pin, teletext request, and a fixed-latency pixel pipeline into a
  user stream. Registers over Avalon-MM with one wait state.
  Assumes the source shares clk_in and holds a word until taken.
*/
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "vep_regs.svh"
module vep_device #(
  parameter int LAT         = `VEP_PIPE_LAT,
  parameter int LINE_CLKS   = `VEP_LINE_CLKS,
  parameter int HSYNC_CLKS  = `VEP_HSYNC_CLKS,
  parameter int FIELD_LINES = `VEP_FIELD_LINES,
  parameter int VSYNC_LINES = `VEP_VSYNC_LINES,
  parameter int VBI_LINES   = `VEP_VBI_LINES
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Avalon-MM slave, word addressed
  input  wire logic [2:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Strap pin
  input  wire logic              slave_address_low_bit_in,
  // Pixel stream to user
  output vep_pkg::vep_pix_t      pix_out,
  output logic                   pix_valid_out,
  input  wire logic              pix_ready_in,
  // Converter enables
  output logic                   dac_b_on_out,
  output logic                   dac_d_on_out,
  // Pins
  vep_if.dev                     lnk
);
  import vep_pkg::*;

  logic [`VEP_CTRL_BITS-1:0] ctrl_r;
  logic [31:0]   sc_inc_r;
  logic [31:0]   sc_phase_r;
  logic          ack_r;
  logic [31:0]   rdata_r;
  logic          adr_s1_r;
  logic          adr_s2_r;
  logic          hs_q_r;
  logic          hs_p_r;
  logic          fs_q_r;
  logic          fs_p_r;
  logic          scr_q_r;
  logic          scr_p_r;
  logic          rtc_r;
  logic [11:0]   hcnt_r;
  logic [9:0]    lcnt_r;
  logic          field_r;
  logic          hs_o_r;
  logic          fs_o_r;
  logic          txt_req_r;
  logic [7:0]    txt_sh_r;
  vep_pix_t      buf_r [0:1];
  logic          wp_r;
  logic          rp_r;
  logic [1:0]    cnt_r;
  vep_pix_t      pd_r [0:LAT-1];
  logic [LAT-1:0] pv_r;

  // Configuration decode
  wire        master  = ctrl_r[`VEP_CTRL_MASTER];
  wire        wide    = ctrl_r[`VEP_CTRL_WIDE];
  wire        txt_en  = ctrl_r[`VEP_CTRL_TXT_EN];
  wire vep_tmode_t tmode =
    vep_tmode_t'(ctrl_r[`VEP_CTRL_TM_HI:`VEP_CTRL_TM_LO]);
  wire vep_sc_fn_t sc_fn =
    vep_sc_fn_t'({ctrl_r[`VEP_CTRL_SC_HI], ctrl_r[`VEP_CTRL_SC_LO]});

  // Bus decode: one wait state, then the access completes
  wire        req     = avs_read_in | avs_write_in;
  wire        do_wr   = avs_write_in & ack_r;
  wire        sel_ctl = avs_address_in == `VEP_REG_CTRL;
  wire        sel_inc = avs_address_in == `VEP_REG_SC_INC;
  wire        sel_sta = avs_address_in == `VEP_REG_STATUS;
  wire        sel_pha = avs_address_in == `VEP_REG_SC_PHASE;
  wire        sel_txt = avs_address_in == `VEP_REG_TXT;
  wire [6:0]  slv_adr = {`VEP_SLAVE_ADDR_HI, adr_s2_r};
  wire [31:0] status  = {12'h000, cnt_r == 2'h2, lcnt_r, field_r,
                         rtc_r, slv_adr};
  wire [31:0] rmux;

  assign rmux = sel_ctl ? {20'h00000, ctrl_r} :
                sel_inc ? sc_inc_r :
                sel_sta ? status :
                sel_pha ? sc_phase_r :
                sel_txt ? {24'h000000, txt_sh_r} : 32'h0000_0000;

  assign avs_waitrequest_out = req & ~ack_r;
  assign avs_readdata_out    = rdata_r;
  assign dac_b_on_out        = ctrl_r[`VEP_CTRL_DAC_B];
  assign dac_d_on_out        = ctrl_r[`VEP_CTRL_DAC_D];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      ctrl_r   <= `VEP_CTRL_RST;
      sc_inc_r <= `VEP_SC_INC_RST;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read_in & ~ack_r) begin
        rdata_r <= rmux;
      end
      if (do_wr && sel_ctl) begin
        ctrl_r <= avs_writedata_in[`VEP_CTRL_BITS-1:0];
      end else if (do_wr && sel_inc) begin
        sc_inc_r <= avs_writedata_in;
      end
    end
  end

  // Strap is a board pin, so it crosses two flops first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adr_s1_r <= 1'b0;
      adr_s2_r <= 1'b0;
    end else begin
      adr_s1_r <= slave_address_low_bit_in;
      adr_s2_r <= adr_s1_r;
    end
  end

  // Control pins sampled on the rising edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_q_r  <= 1'b1;
      hs_p_r  <= 1'b1;
      fs_q_r  <= 1'b1;
      fs_p_r  <= 1'b1;
      scr_q_r <= 1'b0;
      scr_p_r <= 1'b0;
    end else begin
      hs_q_r  <= lnk.hsync;
      hs_p_r  <= hs_q_r;
      fs_q_r  <= lnk.fsync;
      fs_p_r  <= fs_q_r;
      scr_q_r <= lnk.subcarrier_restart_or_realtime_ctl;
      scr_p_r <= scr_q_r;
    end
  end

  // Timing generator: free runs as master, follows pins as slave
  wire line_end = hcnt_r == 12'(LINE_CLKS - 1);
  wire fld_end  = lcnt_r == 10'(FIELD_LINES - 1);
  wire hs_fall  = hs_p_r & ~hs_q_r;
  wire fs_chg   = fs_p_r ^ fs_q_r;
  wire vs_fall  = fs_p_r & ~fs_q_r;
  wire sl_field = (tmode == VEP_TM1) & fs_chg;
  wire sl_vsync = (tmode == VEP_TM2) & vs_fall;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hcnt_r  <= 12'h000;
      lcnt_r  <= 10'h000;
      field_r <= 1'b0;
    end else if (master) begin
      hcnt_r <= line_end ? 12'h000 : hcnt_r + 12'h001;
      if (line_end) begin
        lcnt_r <= fld_end ? 10'h000 : lcnt_r + 10'h001;
        if (fld_end) begin
          field_r <= ~field_r;
        end
      end
    end else begin
      hcnt_r <= hs_fall ? 12'h000 : hcnt_r + 12'h001;
      if (sl_field || sl_vsync) begin
        lcnt_r  <= 10'h000;
        field_r <= sl_field ? fs_q_r : ~field_r;
      end else if (hs_fall) begin
        lcnt_r <= lcnt_r + 10'h001;
      end
    end
  end

  // Master sync launched from the same edge; line sync active low, field pin active low in mode 2, else the field level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_o_r <= 1'b1;
      fs_o_r <= 1'b1;
    end else begin
      hs_o_r <= hcnt_r >= 12'(HSYNC_CLKS);
      fs_o_r <= (tmode == VEP_TM2) ? (lcnt_r >= 10'(VSYNC_LINES)) :
                field_r;
    end
  end

  assign lnk.hs_dev_o  = hs_o_r;
  assign lnk.hs_dev_oe = master;
  assign lnk.fs_dev_o  = fs_o_r;
  assign lnk.fs_dev_oe = master;

  // Subcarrier phase and the shared restart / real-time pin
  wire sc_rise = scr_q_r & ~scr_p_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sc_phase_r <= 32'h0000_0000;
      rtc_r      <= 1'b0;
    end else begin
      if (sc_fn == VEP_SC_RESTART && sc_rise) begin
        sc_phase_r <= 32'h0000_0000;
      end else begin
        sc_phase_r <= sc_phase_r + sc_inc_r;
      end
      if (sc_fn == VEP_SC_RTC) begin
        rtc_r <= scr_q_r;
      end
    end
  end

  // Teletext: request only inside the blanking lines when enabled
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txt_req_r <= 1'b0;
      txt_sh_r  <= 8'h00;
    end else begin
      txt_req_r <= txt_en & (lcnt_r < 10'(VBI_LINES));
      if (txt_req_r) begin
        txt_sh_r <= {txt_sh_r[6:0], lnk.vbi_text_data_in};
      end
    end
  end

  assign lnk.vbi_text_request = txt_req_r;

  // Two-entry buffer; a stalled user backs up into the source
  wire      full = cnt_r == 2'h2;
  wire      push = lnk.blank & ~full;
  wire      adv  = ~pv_r[LAT-1] | pix_ready_in;
  wire      pop  = adv & (cnt_r != 2'h0);
  wire vep_pix_t win = wide ? lnk.pixel_data_bus :
                       {8'h00, lnk.pixel_data_bus[7:0]};

  assign lnk.pix_ready = ~full;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_r[0] <= 16'h0000;
      buf_r[1] <= 16'h0000;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        buf_r[wp_r] <= win;
        wp_r        <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Fixed pipeline; freezes only while the user stalls a full end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pv_r <= '0;
      for (int i = 0; i < LAT; i++) begin
        pd_r[i] <= 16'h0000;
      end
    end else if (adv) begin
      pv_r     <= {pv_r[LAT-2:0], cnt_r != 2'h0};
      pd_r[0]  <= buf_r[rp_r];
      for (int i = 1; i < LAT; i++) begin
        pd_r[i] <= pd_r[i-1];
      end
    end
  end

  assign pix_out       = pd_r[LAT-1];
  assign pix_valid_out = pv_r[LAT-1];

endmodule : vep_device

/* sim/vep_assertions.sv */
/*
  Concurrent checks on the pin bundle between source and encoder.
  Assumes one clock, asynchronous active-low reset, shortened counts.
*/
`timescale 1ns/1ps
module vep_assertions #(
  parameter int LINE_CLKS  = 40,
  parameter int HSYNC_CLKS = 4,
  parameter int VBI_CLKS   = 80
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Pins
  input  wire vep_pkg::vep_pix_t pixel_data_bus,
  input  wire logic              blank,
  input  wire logic              pix_ready,
  input  wire logic              hs_dev_o,
  input  wire logic              hs_dev_oe,
  input  wire logic              fs_dev_oe,
  input  wire logic              vbi_text_request
);
  import vep_pkg::*;
  logic [11:0] lo_cnt_r, lo_cnt_nxt, rq_cnt_r, rq_cnt_nxt;
  // Counters, since pulse widths exceed a short repetition
  assign lo_cnt_nxt = (hs_dev_oe && !hs_dev_o) ? lo_cnt_r + 12'h001 : 12'h000;
  assign rq_cnt_nxt = vbi_text_request ? rq_cnt_r + 12'h001 : 12'h000;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lo_cnt_r <= 12'h000;
      rq_cnt_r <= 12'h000;
    end else begin
      lo_cnt_r <= lo_cnt_nxt;
      rq_cnt_r <= rq_cnt_nxt;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_hs_width: assert property (
    $rose(hs_dev_o) && hs_dev_oe && $past(hs_dev_oe, HSYNC_CLKS)
    |-> lo_cnt_r == HSYNC_CLKS)
    else $error("master line sync pulse width wrong");
  chk_hs_cap: assert property (lo_cnt_r <= HSYNC_CLKS)
    else $error("master line sync low too long");
  chk_line_period: assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !hs_dev_oe)
    $fell(hs_dev_o) |-> ##LINE_CLKS $fell(hs_dev_o))
    else $error("line period wrong");
  chk_reset_slave: assert property (
    $rose(rst_n_in) |-> !hs_dev_oe && !fs_dev_oe && pix_ready
      && !vbi_text_request)
    else $error("reset state not slave and idle");
  chk_oe_pair: assert property (hs_dev_oe == fs_dev_oe)
    else $error("sync pins disagree on master mode");
  chk_word_hold: assert property (
    blank && !pix_ready |=> blank && $stable(pixel_data_bus))
    else $error("refused word not held");
  chk_txt_span: assert property (rq_cnt_r <= VBI_CLKS)
    else $error("teletext request outside its lines");
  chk_txt_gap: assert property (
    $fell(vbi_text_request) |-> !vbi_text_request [*8])
    else $error("teletext request rose again too soon");
endmodule : vep_assertions

/* sim/video_encoder_pixel_port_pins_tb.sv */
/*
  Testbench joining source and encoder front end through the pin bundle.
  Assumes shortened timing counts and a 10 MHz clock.
*/
`timescale 1ns/1ps
`include "vep_regs.svh"
module video_encoder_pixel_port_pins_tb;
  import vep_pkg::*;
  localparam int LAT = 4, LCLK = 40, HCLK = 4, FLN = 6, VSL = 2, VBL = 2;
  logic        clk_in = 1'b0, rst_n_in = 1'b0;
  logic [2:0]  av_a = 3'h0;
  logic        av_rd = 1'b0, av_wr = 1'b0, av_wait, strap = 1'b1;
  logic [31:0] av_wd = 32'h0, av_rdata, av_q;
  vep_pix_t    pix_in = 16'h0, pix_out, exp_q[$];
  logic        pv_in = 1'b0, pr_out, pv_out, pr_in = 1'b1, master = 1'b0;
  logic        scr = 1'b0, dac_b, dac_d, wide = 1'b0, vmode = 1'b0;
  logic        txt_bit = 1'b0;
  int          fails = 0, total_checks = 0, cyc = 0, h_cyc, seen_cyc, n;
  vep_if lnk ();
  vep_source #(.LINE_CLKS(LCLK), .HSYNC_CLKS(HCLK), .FIELD_LINES(FLN),
    .VSYNC_LINES(VSL)) vep_source_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .pix_in(pix_in), .pix_valid_in(pv_in), .pix_ready_out(pr_out),
    .enc_master_in(master), .vsync_mode_in(vmode), .scr_level_in(scr),
    .txt_bit_in(txt_bit), .txt_req_seen_out(), .hsync_seen_out(),
    .fsync_seen_out(), .lnk(lnk));
  vep_device #(.LAT(LAT), .LINE_CLKS(LCLK), .HSYNC_CLKS(HCLK),
    .FIELD_LINES(FLN), .VSYNC_LINES(VSL), .VBI_LINES(VBL)) vep_device_i (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in), .avs_address_in(av_a), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_wd),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
    .slave_address_low_bit_in(strap), .pix_out(pix_out),
    .pix_valid_out(pv_out), .pix_ready_in(pr_in), .dac_b_on_out(dac_b),
    .dac_d_on_out(dac_d), .lnk(lnk));
  vep_assertions #(.LINE_CLKS(LCLK), .HSYNC_CLKS(HCLK), .VBI_CLKS(VBL * LCLK))
    vep_assertions_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .pixel_data_bus(lnk.pixel_data_bus), .blank(lnk.blank),
    .pix_ready(lnk.pix_ready), .hs_dev_o(lnk.hs_dev_o),
    .hs_dev_oe(lnk.hs_dev_oe), .fs_dev_oe(lnk.fs_dev_oe),
    .vbi_text_request(lnk.vbi_text_request));
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) cyc++;
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Output words judged at negedge, where ready and valid are settled
  always @(negedge clk_in) begin
    if (pv_out === 1'b1 && pr_in === 1'b1) begin
      seen_cyc = cyc;
      if (exp_q.size() == 0) chk(1, 0, "extra word");
      else chk(pix_out, exp_q.pop_front(), "word");
    end
  end
  task av(input logic w, input logic [2:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_in);
    av_a <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    @(posedge clk_in);
    while (av_wait !== 1'b0 && t < 20) begin
      @(posedge clk_in);
      t++;
    end
    chk(t < 20, 1, "bus wait");
    av_q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : av
  task rdc(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    av(1'b0, a, 32'h0);
    chk(av_q & m, e, "reg read");
  endtask : rdc
  // Sends up to cnt words; with stop set it quits at the first refusal
  task push(input int cnt, input vep_pix_t base, input bit stop,
            output int k);
    vep_pix_t v;
    int t;
    k = 0;
    t = 0;
    while (k < cnt && t < 200) begin
      v = base + k[15:0];
      @(posedge clk_in);
      pix_in <= v;
      pv_in <= 1'b1;
      @(negedge clk_in);
      t++;
      if (pr_out !== 1'b1 && stop) break;
      if (pr_out === 1'b1) begin
        exp_q.push_back(wide ? v : {8'h00, v[7:0]});
        h_cyc = cyc + 2;
        k++;
      end
    end
    @(posedge clk_in);
    pv_in <= 1'b0;
  endtask : push
  task drain;
    int t;
    t = 0;
    while (exp_q.size() != 0 && t < 200) begin
      @(negedge clk_in);
      t++;
    end
    chk(exp_q.size(), 0, "words lost");
    repeat (10) @(negedge clk_in);
  endtask : drain
  function automatic logic sig(input int s);
    return s == 0 ? lnk.hsync : s == 1 ? lnk.fsync : lnk.vbi_text_request;
  endfunction : sig
  // Length of the next full run of level lvl, first partial run skipped
  task run_len(input int s, input logic lvl, output int r);
    int t;
    r = 0;
    t = 0;
    while (sig(s) === lvl && t < 1000) begin
      @(negedge clk_in);
      t++;
    end
    while (sig(s) !== lvl && t < 1000) begin
      @(negedge clk_in);
      t++;
    end
    while (sig(s) === lvl && t < 1000) begin
      @(negedge clk_in);
      t++;
      r++;
    end
  endtask : run_len
  task s_regs;
    rdc(`VEP_REG_CTRL, 32'h100, 32'hFFF);
    chk({dac_b, dac_d}, 2'b10, "converters after reset");
    rdc(`VEP_REG_STATUS, {`VEP_SLAVE_ADDR_HI, 1'b1}, 32'h7F);
    @(posedge clk_in);
    strap <= 1'b0;
    repeat (2) @(posedge clk_in);
    rdc(`VEP_REG_STATUS, {`VEP_SLAVE_ADDR_HI, 1'b0}, 32'h7F);
    rdc(3'h7, 32'h0, 32'hFFFF_FFFF);
    av(1'b1, `VEP_REG_CTRL, 32'h208);
    @(negedge clk_in);
    chk({dac_b, dac_d}, 2'b01, "converters written");
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdc(`VEP_REG_CTRL, 32'h100, 32'hFFF);
  endtask : s_regs
  task s_stream;
    push(1, 16'hA5C3, 1'b0, n);
    drain();
    chk(seen_cyc - h_cyc, LAT, "latency");
    push(5, 16'h1234, 1'b0, n);
    drain();
    av(1'b1, `VEP_REG_CTRL, 32'h108);
    wide = 1'b1;
    push(5, 16'hBEE0, 1'b0, n);
    drain();
    @(posedge clk_in);
    pr_in <= 1'b0;
    push(40, 16'h4000, 1'b1, n);
    chk(n < 40, 1, "stall refused");
    @(posedge clk_in);
    pr_in <= 1'b1;
    drain();
  endtask : s_stream
  task s_timing;
    av(1'b1, `VEP_REG_CTRL, 32'h101);
    master <= 1'b1;
    run_len(0, 1'b0, n);
    chk(n, 4, "line sync low");
    run_len(0, 1'b1, n);
    chk(n, 36, "line sync high");
    av(1'b1, `VEP_REG_CTRL, 32'h103);
    run_len(1, 1'b1, n);
    chk(n, 240, "field level");
    av(1'b1, `VEP_REG_CTRL, 32'h105);
    run_len(1, 1'b0, n);
    chk(n, 80, "vertical sync low");
    av(1'b1, `VEP_REG_CTRL, 32'h141);
    run_len(2, 1'b1, n);
    chk(n, 80, "teletext request span");
    rdc(`VEP_REG_TXT, 32'h00, 32'hFF);
    txt_bit <= 1'b1;
    run_len(2, 1'b1, n);
    chk(n, 80, "second teletext span");
    rdc(`VEP_REG_TXT, 32'hFF, 32'hFF);
    av(1'b1, `VEP_REG_CTRL, 32'h101);
    @(posedge clk_in);
    n = 0;
    repeat (300) begin
      @(negedge clk_in);
      if (lnk.vbi_text_request !== 1'b0) n++;
    end
    chk(n, 0, "teletext request while off");
    av(1'b1, `VEP_REG_CTRL, 32'h100);
    master <= 1'b0;
    @(negedge clk_in);
    chk(lnk.hs_dev_oe, 1'b0, "slave drives no sync");
    run_len(0, 1'b0, n);
    chk(n, 4, "source line sync");
    av(1'b1, `VEP_REG_CTRL, 32'h104);
    vmode <= 1'b1;
    run_len(1, 1'b0, n);
    chk(n, 80, "source vertical sync low");
  endtask : s_timing
  task s_subcarrier;
    av(1'b1, `VEP_REG_SC_INC, 32'h1);
    av(1'b1, `VEP_REG_CTRL, 32'h110);
    repeat (30) @(posedge clk_in);
    scr <= 1'b1;
    repeat (4) @(posedge clk_in);
    av(1'b0, `VEP_REG_SC_PHASE, 32'h0);
    chk(av_q < 16, 1, "phase restarted");
    scr <= 1'b0;
    av(1'b1, `VEP_REG_CTRL, 32'h100);
    repeat (30) @(posedge clk_in);
    scr <= 1'b1;
    repeat (4) @(posedge clk_in);
    av(1'b0, `VEP_REG_SC_PHASE, 32'h0);
    chk(av_q >= 32, 1, "no restart when off");
    av(1'b1, `VEP_REG_CTRL, 32'h120);
    rdc(`VEP_REG_STATUS, 32'h80, 32'h80);
    scr <= 1'b0;
    repeat (3) @(posedge clk_in);
    rdc(`VEP_REG_STATUS, 32'h0, 32'h80);
  endtask : s_subcarrier
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    s_regs();
    s_stream();
    s_timing();
    s_subcarrier();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    close_out();
  end
endmodule : video_encoder_pixel_port_pins_tb
